// file: sfwl_pkg.sv
package sfwl_pkg;
  localparam logic [7:0] TX_WATERMARK_OFF = 8'h18;
  localparam logic [7:0] RX_WATERMARK_OFF = 8'h1c;
  localparam logic [7:0] TX_FILL_COUNT_OFF = 8'h20;
  localparam logic [7:0] RX_FILL_COUNT_OFF = 8'h24;
  localparam logic [7:0] CTRL_ENABLE_OFF = 8'h08;
  localparam logic [7:0] IRQ_STATUS_OFF = 8'h30;
  localparam logic [7:0] IRQ_MASK_OFF = 8'h34;
  localparam int WM_W = 3;
  localparam int CNT_W = 4;
  localparam int IRQ_W = 2;
  localparam int IRQ_TXE_BIT = 0;
  localparam int IRQ_RXF_BIT = 1;
  localparam logic [2:0] WM_RESET = 3'h0;
  localparam logic [3:0] CNT_RESET = 4'h0;
  localparam logic [1:0] MASK_RESET = 2'h0;
  localparam logic [4:0] TX_DEPTH_DEF = 5'h08;
  localparam logic [4:0] RX_DEPTH_DEF = 5'h08;
endpackage : sfwl_pkg

// file: sfwl_cmp.sv
`timescale 1ns/1ns
// Threshold comparators; purely combinational
module sfwl_cmp (
  // Levels
  input wire logic [3:0] tx_count,
  input wire logic [3:0] rx_count,
  input wire logic [2:0] tx_wm,
  input wire logic [2:0] rx_wm,
  // Conditions
  output logic txe_cond,
  output logic rxf_cond
);
  assign txe_cond = ({1'b0, tx_wm} >= tx_count);
  assign rxf_cond = ({1'b0, rx_wm} + 4'h1 <= rx_count);
endmodule : sfwl_cmp

// file: sfwl_top.sv
`timescale 1ns/1ns
module sfwl_top #(
  parameter logic [4:0] TX_DEPTH = sfwl_pkg::TX_DEPTH_DEF,
  parameter logic [4:0] RX_DEPTH = sfwl_pkg::RX_DEPTH_DEF
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // FIFO occupancy from the controller
  input wire logic [3:0] tx_level,
  input wire logic [3:0] rx_level,
  // Requests and enable
  output logic txe_irq,
  output logic rxf_irq,
  output logic irq,
  output logic ctrl_enable
);

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [2:0] tx_wm;
    logic [2:0] rx_wm;
    logic [3:0] tx_cnt;
    logic [3:0] rx_cnt;
    logic en;
    logic [1:0] sts;
    logic [1:0] mask;
    logic txe;
    logic rxf;
    logic irq;
    logic [31:0] rdata;
    logic rdy;
    logic err;
  } sfwl_state_t;

  // Reset image of the whole state
  localparam sfwl_state_t ST_RESET = '{
    tx_wm: sfwl_pkg::WM_RESET,
    rx_wm: sfwl_pkg::WM_RESET,
    tx_cnt: sfwl_pkg::CNT_RESET,
    rx_cnt: sfwl_pkg::CNT_RESET,
    en: 1'h0,
    sts: 2'h0,
    mask: sfwl_pkg::MASK_RESET,
    txe: 1'h0,
    rxf: 1'h0,
    irq: 1'h0,
    rdata: 32'h0,
    rdy: 1'h0,
    err: 1'h0
  };

  sfwl_state_t st_q;
  sfwl_state_t st_d;
  logic txe_cond;
  logic rxf_cond;
  logic setup;
  logic [1:0] ev;

  ////////////////////////////////////////////////////////////////////////////
  // Levels come from logic on pclk, so no synchroniser; compare registered copies
  sfwl_cmp u_cmp (
    .tx_count(st_q.tx_cnt),
    .rx_count(st_q.rx_cnt),
    .tx_wm(st_q.tx_wm),
    .rx_wm(st_q.rx_wm),
    .txe_cond(txe_cond),
    .rxf_cond(rxf_cond)
  );

  // One-cycle answer: pready rises in the access cycle after setup
  assign setup = psel && !penable;
  assign ev = {rxf_cond, txe_cond};

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_d = st_q;
    st_d.tx_cnt = tx_level;
    st_d.rx_cnt = rx_level;
    st_d.txe = txe_cond;
    st_d.rxf = rxf_cond;
    st_d.rdy = setup;
    st_d.err = 1'b0;
    st_d.sts = st_q.sts | ev;
    if (psel && penable && st_q.rdy && pwrite) begin
      if (paddr == sfwl_pkg::TX_WATERMARK_OFF) begin
        if ({2'b00, pwdata[2:0]} < TX_DEPTH) begin
          st_d.tx_wm = pwdata[2:0];
        end
      end else if (paddr == sfwl_pkg::RX_WATERMARK_OFF) begin
        if ({2'b00, pwdata[2:0]} <= RX_DEPTH) begin
          st_d.rx_wm = pwdata[2:0];
        end
      end else if (paddr == sfwl_pkg::CTRL_ENABLE_OFF) begin
        st_d.en = pwdata[0];
      end else if (paddr == sfwl_pkg::IRQ_STATUS_OFF) begin
        // New events win over the clear
        st_d.sts = (st_q.sts & ~pwdata[1:0]) | ev;
      end else if (paddr == sfwl_pkg::IRQ_MASK_OFF) begin
        st_d.mask = pwdata[1:0];
      end
    end
    if (setup) begin
      st_d.rdata = 32'h0;
      if (paddr == sfwl_pkg::TX_WATERMARK_OFF) begin
        st_d.rdata = {29'h0, st_q.tx_wm};
      end else if (paddr == sfwl_pkg::RX_WATERMARK_OFF) begin
        st_d.rdata = {29'h0, st_q.rx_wm};
      end else if (paddr == sfwl_pkg::TX_FILL_COUNT_OFF) begin
        st_d.rdata = {28'h0, st_q.tx_cnt};
      end else if (paddr == sfwl_pkg::RX_FILL_COUNT_OFF) begin
        st_d.rdata = {28'h0, st_q.rx_cnt};
      end else if (paddr == sfwl_pkg::CTRL_ENABLE_OFF) begin
        st_d.rdata = {31'h0, st_q.en};
      end else if (paddr == sfwl_pkg::IRQ_STATUS_OFF) begin
        st_d.rdata = {30'h0, st_q.sts};
      end else if (paddr == sfwl_pkg::IRQ_MASK_OFF) begin
        st_d.rdata = {30'h0, st_q.mask};
      end else begin
        st_d.err = 1'b1;
      end
    end
    st_d.irq = |(st_d.sts & st_d.mask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= ST_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  assign prdata = st_q.rdata;
  assign pready = st_q.rdy;
  assign pslverr = st_q.err;
  assign txe_irq = st_q.txe;
  assign rxf_irq = st_q.rxf;
  assign irq = st_q.irq;
  assign ctrl_enable = st_q.en;

  ////////////////////////////////////////////////////////////////////////////
  // Level checks skip the release edge, where $past would still see the reset image
  property p_txe_level;
    @(posedge pclk) disable iff (!presetn)
      $past(presetn) |-> (txe_irq == ({1'b0, $past(st_q.tx_wm)} >= $past(st_q.tx_cnt)));
  endproperty
  a_txe_level: assert property (p_txe_level) else $error("txe level wrong");

  property p_rxf_level;
    @(posedge pclk) disable iff (!presetn)
      $past(presetn) |-> (rxf_irq == ({1'b0, $past(st_q.rx_wm)} + 4'h1 <= $past(st_q.rx_cnt)));
  endproperty
  a_rxf_level: assert property (p_rxf_level) else $error("rxf level wrong");

  property p_tx_bad_ignored;
    @(posedge pclk) disable iff (!presetn)
      (psel && penable && pready && pwrite && paddr == sfwl_pkg::TX_WATERMARK_OFF
       && {2'b00, pwdata[2:0]} >= TX_DEPTH) |=> $stable(st_q.tx_wm);
  endproperty
  a_tx_bad_ignored: assert property (p_tx_bad_ignored) else $error("tx wm overwritten");

  property p_tx_write;
    @(posedge pclk) disable iff (!presetn)
      (psel && penable && pready && pwrite && paddr == sfwl_pkg::TX_WATERMARK_OFF
       && {2'b00, pwdata[2:0]} < TX_DEPTH) |=> (st_q.tx_wm == $past(pwdata[2:0]));
  endproperty
  a_tx_write: assert property (p_tx_write) else $error("tx wm not written");

  property p_rx_bad_ignored;
    @(posedge pclk) disable iff (!presetn)
      (psel && penable && pready && pwrite && paddr == sfwl_pkg::RX_WATERMARK_OFF
       && {2'b00, pwdata[2:0]} > RX_DEPTH) |=> $stable(st_q.rx_wm);
  endproperty
  a_rx_bad_ignored: assert property (p_rx_bad_ignored) else $error("rx wm overwritten");

  property p_rx_write;
    @(posedge pclk) disable iff (!presetn)
      (psel && penable && pready && pwrite && paddr == sfwl_pkg::RX_WATERMARK_OFF
       && {2'b00, pwdata[2:0]} <= RX_DEPTH)
      |=> (st_q.rx_wm == $past(pwdata[2:0]));
  endproperty
  a_rx_write: assert property (p_rx_write) else $error("rx wm not written");

  property p_tx_count;
    @(posedge pclk) disable iff (!presetn)
      $past(presetn) |-> (st_q.tx_cnt == $past(tx_level));
  endproperty
  a_tx_count: assert property (p_tx_count) else $error("tx count stale");

  property p_rx_count;
    @(posedge pclk) disable iff (!presetn)
      $past(presetn) |-> (st_q.rx_cnt == $past(rx_level));
  endproperty
  a_rx_count: assert property (p_rx_count) else $error("rx count stale");

  property p_en_only_write;
    @(posedge pclk) disable iff (!presetn)
      !(psel && penable && pready && pwrite && paddr == sfwl_pkg::CTRL_ENABLE_OFF)
      |=> $stable(ctrl_enable);
  endproperty
  a_en_only_write: assert property (p_en_only_write) else $error("enable changed");

  property p_txe_drop;
    @(posedge pclk) disable iff (!presetn)
      (txe_irq && !txe_cond) |=> !txe_irq;
  endproperty
  a_txe_drop: assert property (p_txe_drop) else $error("txe held");

  property p_rxf_drop;
    @(posedge pclk) disable iff (!presetn)
      (rxf_irq && !rxf_cond) |=> !rxf_irq;
  endproperty
  a_rxf_drop: assert property (p_rxf_drop) else $error("rxf held");

  // The summary line follows status and mask in the same edge
  property p_irq_level;
    @(posedge pclk) disable iff (!presetn)
      irq == |(st_q.sts & st_q.mask);
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("irq not status and mask");

  ////////////////////////////////////////////////////////////////////////////
  // Bus answer: exactly one access cycle, error only together with ready
  property p_ready_answer;
    @(posedge pclk) disable iff (!presetn)
      (psel && !penable) |=> pready;
  endproperty
  a_ready_answer: assert property (p_ready_answer) else $error("no ready after setup");

  property p_ready_pulse;
    @(posedge pclk) disable iff (!presetn)
      pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready held too long");

  property p_err_with_ready;
    @(posedge pclk) disable iff (!presetn)
      pslverr |-> pready;
  endproperty
  a_err_with_ready: assert property (p_err_with_ready) else $error("error without ready");

  property p_rd_tx_wm;
    @(posedge pclk) disable iff (!presetn)
      (setup && paddr == sfwl_pkg::TX_WATERMARK_OFF) |=> (prdata == {29'h0, $past(st_q.tx_wm)});
  endproperty
  a_rd_tx_wm: assert property (p_rd_tx_wm) else $error("tx wm read wrong");

  property p_rd_rx_wm;
    @(posedge pclk) disable iff (!presetn)
      (setup && paddr == sfwl_pkg::RX_WATERMARK_OFF) |=> (prdata == {29'h0, $past(st_q.rx_wm)});
  endproperty
  a_rd_rx_wm: assert property (p_rd_rx_wm) else $error("rx wm read wrong");

  property p_rd_tx_cnt;
    @(posedge pclk) disable iff (!presetn)
      (setup && paddr == sfwl_pkg::TX_FILL_COUNT_OFF) |=> (prdata == {28'h0, $past(st_q.tx_cnt)});
  endproperty
  a_rd_tx_cnt: assert property (p_rd_tx_cnt) else $error("tx count read wrong");

  property p_rd_rx_cnt;
    @(posedge pclk) disable iff (!presetn)
      (setup && paddr == sfwl_pkg::RX_FILL_COUNT_OFF) |=> (prdata == {28'h0, $past(st_q.rx_cnt)});
  endproperty
  a_rd_rx_cnt: assert property (p_rd_rx_cnt) else $error("rx count read wrong");

  property p_rd_en;
    @(posedge pclk) disable iff (!presetn)
      (setup && paddr == sfwl_pkg::CTRL_ENABLE_OFF) |=> (prdata == {31'h0, $past(st_q.en)});
  endproperty
  a_rd_en: assert property (p_rd_en) else $error("enable read wrong");

  property p_rd_sts;
    @(posedge pclk) disable iff (!presetn)
      (setup && paddr == sfwl_pkg::IRQ_STATUS_OFF) |=> (prdata == {30'h0, $past(st_q.sts)});
  endproperty
  a_rd_sts: assert property (p_rd_sts) else $error("status read wrong");

  property p_en_write;
    @(posedge pclk) disable iff (!presetn)
      (psel && penable && pready && pwrite && paddr == sfwl_pkg::CTRL_ENABLE_OFF)
      |=> (ctrl_enable == $past(pwdata[0]));
  endproperty
  a_en_write: assert property (p_en_write) else $error("enable not written");

  property p_mask_write;
    @(posedge pclk) disable iff (!presetn)
      (psel && penable && pready && pwrite && paddr == sfwl_pkg::IRQ_MASK_OFF)
      |=> (st_q.mask == $past(pwdata[1:0]));
  endproperty
  a_mask_write: assert property (p_mask_write) else $error("mask not written");

  ////////////////////////////////////////////////////////////////////////////
  // Per-bit status: the event sets its bit, a written one clears it unless the event persists
  for (genvar g = 0; g < sfwl_pkg::IRQ_W; g++) begin : g_sts_chk
    property p_sts_set;
      @(posedge pclk) disable iff (!presetn)
        ($past(presetn) && ev[g]) |=> st_q.sts[g];
    endproperty
    a_sts_set: assert property (p_sts_set) else $error("status event lost");

    property p_sts_clear;
      @(posedge pclk) disable iff (!presetn)
        (psel && penable && pready && pwrite && paddr == sfwl_pkg::IRQ_STATUS_OFF && pwdata[g] && !ev[g])
        |=> !st_q.sts[g];
    endproperty
    a_sts_clear: assert property (p_sts_clear) else $error("status bit not cleared");
  end

  property p_cov_txe;
    @(posedge pclk) disable iff (!presetn) $rose(txe_irq);
  endproperty
  c_txe: cover property (p_cov_txe);

  property p_cov_rxf;
    @(posedge pclk) disable iff (!presetn) $fell(rxf_irq);
  endproperty
  c_rxf: cover property (p_cov_rxf);

  property p_cov_irq;
    @(posedge pclk) disable iff (!presetn) $rose(irq);
  endproperty
  c_irq: cover property (p_cov_irq);

  property p_cov_tx_reject;
    @(posedge pclk) disable iff (!presetn)
      psel && penable && pready && pwrite && paddr == sfwl_pkg::TX_WATERMARK_OFF
      && {2'b00, pwdata[2:0]} >= TX_DEPTH;
  endproperty
  c_tx_reject: cover property (p_cov_tx_reject);

  property p_cov_rx_reject;
    @(posedge pclk) disable iff (!presetn)
      psel && penable && pready && pwrite && paddr == sfwl_pkg::RX_WATERMARK_OFF
      && {2'b00, pwdata[2:0]} > RX_DEPTH;
  endproperty
  c_rx_reject: cover property (p_cov_rx_reject);

endmodule : sfwl_top

// file: testbench.sv
`timescale 1ns/1ns
module testbench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic txe_irq, rxf_irq, irq, ctrl_enable;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] tx_level, rx_level;
  int errors = 0;
  int checks_done = 0;
  // Shallow depths so that refusal boundaries sit inside the 3-bit field
  sfwl_top #(.TX_DEPTH(5'h05), .RX_DEPTH(5'h05)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tx_level(tx_level), .rx_level(rx_level), .txe_irq(txe_irq), .rxf_irq(rxf_irq),
    .irq(irq), .ctrl_enable(ctrl_enable));
  ////////////////////////////////////////////////////////////
  task automatic test_done();
    if (errors == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // Entered just after a rising edge, returns just after one idle edge past the completing edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Ready is looked at mid-cycle, where it has settled, not in the edge's own time step
    for (n = 0; n < 16; n++) begin
      @(negedge pclk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    err = pslverr;
    @(posedge pclk);
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
    if (n == 16) begin
      errors++;
      test_done();
    end
  endtask : apb
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rdc
  // Level path takes two edges, status and irq land on the second as well; two spare edges
  task automatic lvl(input logic [3:0] t, input logic [3:0] r);
    tx_level <= t; rx_level <= r;
    repeat (4) @(posedge pclk);
  endtask : lvl
  ////////////////////////////////////////////////////////////
  task automatic s_watermarks();
    apb(1'b1, 8'h18, 32'hffff_fff3);
    rdc(8'h18, 32'h3);
    apb(1'b1, 8'h18, 32'h5);
    rdc(8'h18, 32'h3);
    apb(1'b1, 8'h18, 32'h4);
    rdc(8'h18, 32'h4);
    apb(1'b1, 8'h1c, 32'h5);
    rdc(8'h1c, 32'h5);
    apb(1'b1, 8'h1c, 32'h6);
    rdc(8'h1c, 32'h5);
  endtask : s_watermarks
  task automatic s_levels();
    lvl(4'h4, 4'h5);
    chk({31'h0, txe_irq}, 32'h1);
    chk({31'h0, rxf_irq}, 32'h0);
    lvl(4'h5, 4'h6);
    chk({31'h0, txe_irq}, 32'h0);
    chk({31'h0, rxf_irq}, 32'h1);
    apb(1'b1, 8'h20, 32'hf);
    rdc(8'h20, 32'h5);
    rdc(8'h24, 32'h6);
    lvl(4'h5, 4'h5);
    chk({31'h0, rxf_irq}, 32'h0);
  endtask : s_levels
  task automatic s_irq();
    apb(1'b1, 8'h30, 32'h3);
    apb(1'b1, 8'h34, 32'h1);
    chk({31'h0, irq}, 32'h0);
    lvl(4'h0, 4'h5);
    chk({31'h0, irq}, 32'h1);
    rdc(8'h30, 32'h1);
    lvl(4'h5, 4'h5);
    apb(1'b1, 8'h30, 32'h1);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    lvl(4'h0, 4'h5);
    apb(1'b1, 8'h34, 32'h0);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
  endtask : s_irq
  task automatic s_enable();
    apb(1'b1, 8'h08, 32'h1);
    apb(1'b1, 8'h18, 32'h0);
    chk({31'h0, ctrl_enable}, 32'h1);
    apb(1'b1, 8'h08, 32'h0);
    chk({31'h0, ctrl_enable}, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    chk({31'h0, err}, 32'h1);
  endtask : s_enable
  ////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0; tx_level = 4'h0; rx_level = 4'h0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    rdc(8'h18, 32'h0);
    rdc(8'h1c, 32'h0);
    rdc(8'h20, 32'h0);
    rdc(8'h24, 32'h0);
    chk({31'h0, txe_irq}, 32'h1);
    s_watermarks();
    s_levels();
    s_irq();
    s_enable();
    test_done();
  end
endmodule : testbench
